/* File: pkg/hqsc_pkg.sv */
// Purpose: shared constants for halt and quick stop control
// Assumes: register offsets are fieldbus word indices
// Notes: currents in 0.01 A rms steps
package hqsc_pkg;
  localparam logic [15:0] OFS_QS_RAMP_LO = 16'h0624;
  localparam logic [15:0] OFS_QS_RAMP_HI = 16'h0625;
  localparam logic [15:0] OFS_HALT_TYPE = 16'h062E;
  localparam logic [15:0] OFS_QS_REACT = 16'h0630;
  localparam logic [15:0] OFS_HALT_CUR = 16'h111C;
  localparam logic [15:0] OFS_QS_CUR = 16'h111A;
  localparam logic [15:0] OFS_STATUS = 16'h1120;
  localparam logic [31:0] QS_RAMP_RST = 32'h0000_1770;
  localparam logic [31:0] QS_RAMP_MIN = 32'h0000_0001;
  localparam logic [31:0] QS_RAMP_MAX = 32'h7FFF_FFFF;
  localparam logic [15:0] HALT_TYPE_RST = 16'h0001;
  localparam logic [15:0] QS_REACT_RST = 16'h0006;
  localparam logic [15:0] CUR_RST = 16'hFFFF;
  localparam logic [15:0] HALT_RAMP = 16'h0001;
  localparam logic [15:0] HALT_TORQUE = 16'h0003;
  localparam logic [15:0] QS_TQ_FAULT = 16'hFFFE;
  localparam logic [15:0] QS_RAMP_FAULT = 16'hFFFF;
  localparam logic [15:0] QS_RAMP_STAY = 16'h0006;
  localparam logic [15:0] QS_TQ_STAY = 16'h0007;
  localparam logic [3:0] OPST_ENABLED = 4'h6;
  localparam logic [3:0] OPST_QS_ACTIVE = 4'h7;
  localparam logic [3:0] OPST_FAULT = 4'h9;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_HALT_DEC = 3'b001,
    ST_HALT_HOLD = 3'b011,
    ST_QS_DEC = 3'b010,
    ST_QS_ACTIVE = 3'b110,
    ST_FAULT = 3'b111
  } hqsc_state_e;
endpackage

/* File: logic/hqsc_cur_min.sv */
// Purpose: lowest of four current limits
// Assumes: all values in 0.01 A rms steps
// Notes: registered, one cycle latency
`timescale 1ns/1ps
module hqsc_cur_min (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] stop_cur,
  input wire logic [15:0] motor_cur,
  input wire logic [15:0] stage_cur,
  input wire logic [15:0] i2t_cur,
  output logic [15:0] lim_r
);
  function automatic logic [15:0] min2(input logic [15:0] a, input logic [15:0] b);
    min2 = (a < b) ? a : b;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lim_r <= 16'h0000;
    end else begin
      lim_r <= min2(min2(stop_cur, motor_cur), min2(stage_cur, i2t_cur));
    end
  end
endmodule

/* File: logic/hqsc_top.sv */
// Purpose: halt and quick stop sequencing with stop parameter registers
// Assumes: velocity profile reports zero speed; parameters written by word index
// Notes: 32-bit ramp written as low then high word
// Functional notes
// (RULE_01) a halt suspends the movement so it can resume rather than discarding it.
// (RULE_02) halt comes from the halt input or a fieldbus halt command.
// (RULE_03) halt selector 1 picks the profile ramp and 3 the torque ramp, signed 16 bit.
// (RULE_04) writes to both stop selectors are ignored while a ramp is decelerating.
// (RULE_05) halt current limit is the lowest of halt, motor peak, stage peak and i2t.
// (RULE_06) halt current is unsigned 16 bit in 0.01 A rms, bounded only by its range.
// (RULE_07) halt ramp deceleration uses the general profile deceleration.
// (RULE_08) halt current changes act at once, even mid stop.
// (RULE_09) quick stop starts on class 1 or 2 errors or a fieldbus quick stop command.
// (RULE_10) quick stop selector -2,-1,6,7 choose ramp type and final state.
// (RULE_11) after quick stop deceleration go to state 9 fault or 7 quick stop active.
// (RULE_12) quick stop ramp is 32 bit, 1 to 2147483647, reset 6000, used from next movement.
// (RULE_13) quick stop current limit is lowest of qs current, motor, stage and i2t.
// (RULE_14) after halt deceleration hold standstill until halt drops, then resume.
`timescale 1ns/1ps
module hqsc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic par_wr,
  input wire logic [15:0] par_addr,
  input wire logic [15:0] par_wdata,
  output logic [15:0] par_rdata_r,
  input wire logic halt_in,
  input wire logic halt_cmd,
  input wire logic qs_cmd,
  input wire logic err_class1,
  input wire logic err_class2,
  input wire logic fault_reset,
  input wire logic move_start,
  input wire logic at_standstill,
  input wire logic [31:0] profile_decel,
  input wire logic [15:0] motor_peak_current,
  input wire logic [15:0] stage_peak_current,
  input wire logic [15:0] i2t_current,
  output logic stopping_r,
  output logic torque_ramp_r,
  output logic [31:0] active_decel_r,
  output logic [15:0] active_current_r,
  output logic resume_r,
  output logic [3:0] op_state_r
);
  logic [31:0] qs_ramp_r;
  logic [31:0] qs_ramp_act_r;
  logic [15:0] qs_ramp_lo_r;
  logic [15:0] halt_decel_type;
  logic [15:0] quick_stop_reaction;
  logic [15:0] halt_current_limit;
  logic [15:0] quick_stop_current_limit;
  hqsc_pkg::hqsc_state_e st_r, st_nxt;
  logic halt_req, qs_req, ramp_busy, qs_torque, qs_fault;
  logic [15:0] halt_lim, qs_lim;
  logic [15:0] par_rdata_nxt;

  function automatic logic sel_wr(input logic [15:0] ofs);
    sel_wr = par_wr && (par_addr == ofs);
  endfunction

  assign halt_req = halt_in | halt_cmd; // see (RULE_02)
  assign qs_req = err_class1 | err_class2 | qs_cmd; // see (RULE_09)
  assign ramp_busy = (st_r == hqsc_pkg::ST_HALT_DEC) || (st_r == hqsc_pkg::ST_QS_DEC);
  // see (RULE_10)
  assign qs_torque = (quick_stop_reaction == hqsc_pkg::QS_TQ_FAULT) ||
                     (quick_stop_reaction == hqsc_pkg::QS_TQ_STAY);
  assign qs_fault = (quick_stop_reaction == hqsc_pkg::QS_TQ_FAULT) ||
                    (quick_stop_reaction == hqsc_pkg::QS_RAMP_FAULT);

  // selectors locked while a ramp runs; only documented codes accepted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halt_decel_type <= hqsc_pkg::HALT_TYPE_RST;
      quick_stop_reaction <= hqsc_pkg::QS_REACT_RST;
    end else begin
      if (sel_wr(hqsc_pkg::OFS_HALT_TYPE) && !ramp_busy &&
          (par_wdata == hqsc_pkg::HALT_RAMP || par_wdata == hqsc_pkg::HALT_TORQUE)) begin
        halt_decel_type <= par_wdata; // see (RULE_04) (RULE_03)
      end
      if (sel_wr(hqsc_pkg::OFS_QS_REACT) && !ramp_busy &&
          (par_wdata == hqsc_pkg::QS_TQ_FAULT || par_wdata == hqsc_pkg::QS_RAMP_FAULT ||
           par_wdata == hqsc_pkg::QS_RAMP_STAY || par_wdata == hqsc_pkg::QS_TQ_STAY)) begin
        quick_stop_reaction <= par_wdata; // see (RULE_04)
      end
    end
  end

  // currents: full 16-bit range, no clamp to ratings
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halt_current_limit <= hqsc_pkg::CUR_RST;
      quick_stop_current_limit <= hqsc_pkg::CUR_RST;
    end else begin
      if (sel_wr(hqsc_pkg::OFS_HALT_CUR)) begin
        halt_current_limit <= par_wdata; // see (RULE_06)
      end
      if (sel_wr(hqsc_pkg::OFS_QS_CUR)) begin
        quick_stop_current_limit <= par_wdata;
      end
    end
  end

  // out-of-range ramp values dropped, whole word checked on the high half
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      qs_ramp_r <= hqsc_pkg::QS_RAMP_RST;
      qs_ramp_lo_r <= hqsc_pkg::QS_RAMP_RST[15:0];
    end else begin
      if (sel_wr(hqsc_pkg::OFS_QS_RAMP_LO)) begin
        qs_ramp_lo_r <= par_wdata;
      end
      if (sel_wr(hqsc_pkg::OFS_QS_RAMP_HI) &&
          {par_wdata, qs_ramp_lo_r} >= hqsc_pkg::QS_RAMP_MIN &&
          {par_wdata, qs_ramp_lo_r} <= hqsc_pkg::QS_RAMP_MAX) begin
        qs_ramp_r <= {par_wdata, qs_ramp_lo_r}; // see (RULE_12)
      end
    end
  end

  // ramp latched at movement start so a change waits for the next move
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      qs_ramp_act_r <= hqsc_pkg::QS_RAMP_RST;
    end else if (move_start && st_r == hqsc_pkg::ST_RUN) begin
      qs_ramp_act_r <= qs_ramp_r; // see (RULE_12)
    end
  end

  always_comb begin
    case (par_addr)
      hqsc_pkg::OFS_QS_RAMP_LO: par_rdata_nxt = qs_ramp_r[15:0];
      hqsc_pkg::OFS_QS_RAMP_HI: par_rdata_nxt = qs_ramp_r[31:16];
      hqsc_pkg::OFS_HALT_TYPE: par_rdata_nxt = halt_decel_type;
      hqsc_pkg::OFS_QS_REACT: par_rdata_nxt = quick_stop_reaction;
      hqsc_pkg::OFS_HALT_CUR: par_rdata_nxt = halt_current_limit;
      hqsc_pkg::OFS_QS_CUR: par_rdata_nxt = quick_stop_current_limit;
      hqsc_pkg::OFS_STATUS: par_rdata_nxt = {9'h000, st_r, op_state_r};
      default: par_rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      par_rdata_r <= 16'h0000;
    end else begin
      par_rdata_r <= par_rdata_nxt;
    end
  end

  // quick stop outranks halt
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      hqsc_pkg::ST_RUN: begin
        if (qs_req) begin
          st_nxt = hqsc_pkg::ST_QS_DEC; // see (RULE_09)
        end else if (halt_req) begin
          st_nxt = hqsc_pkg::ST_HALT_DEC; // see (RULE_01)
        end
      end
      hqsc_pkg::ST_HALT_DEC: begin
        if (qs_req) begin
          st_nxt = hqsc_pkg::ST_QS_DEC;
        end else if (at_standstill) begin
          st_nxt = hqsc_pkg::ST_HALT_HOLD; // see (RULE_14)
        end
      end
      hqsc_pkg::ST_HALT_HOLD: begin
        if (qs_req) begin
          st_nxt = hqsc_pkg::ST_QS_DEC;
        end else if (!halt_req) begin
          st_nxt = hqsc_pkg::ST_RUN; // see (RULE_14)
        end
      end
      hqsc_pkg::ST_QS_DEC: begin
        if (at_standstill) begin
          st_nxt = qs_fault ? hqsc_pkg::ST_FAULT : hqsc_pkg::ST_QS_ACTIVE; // see (RULE_11)
        end
      end
      hqsc_pkg::ST_QS_ACTIVE, hqsc_pkg::ST_FAULT: begin
        if (fault_reset && !qs_req) begin
          st_nxt = hqsc_pkg::ST_RUN;
        end
      end
      default: st_nxt = hqsc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= hqsc_pkg::ST_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // live register value feeds the limit, so edits apply mid stop
  hqsc_cur_min u_halt_min (
    .clk(clk),
    .rst_n(rst_n),
    .stop_cur(halt_current_limit),
    .motor_cur(motor_peak_current),
    .stage_cur(stage_peak_current),
    .i2t_cur(i2t_current),
    .lim_r(halt_lim)
  ); // see (RULE_05) (RULE_08)
  hqsc_cur_min u_qs_min (
    .clk(clk),
    .rst_n(rst_n),
    .stop_cur(quick_stop_current_limit),
    .motor_cur(motor_peak_current),
    .stage_cur(stage_peak_current),
    .i2t_cur(i2t_current),
    .lim_r(qs_lim)
  ); // see (RULE_13)

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stopping_r <= 1'b0;
      torque_ramp_r <= 1'b0;
      active_decel_r <= 32'h0000_0000;
      active_current_r <= 16'h0000;
      resume_r <= 1'b0;
      op_state_r <= hqsc_pkg::OPST_ENABLED;
    end else begin
      stopping_r <= (st_nxt == hqsc_pkg::ST_HALT_DEC) || (st_nxt == hqsc_pkg::ST_QS_DEC);
      resume_r <= (st_r == hqsc_pkg::ST_HALT_HOLD) && (st_nxt == hqsc_pkg::ST_RUN); // see (RULE_14)
      case (st_nxt)
        hqsc_pkg::ST_HALT_DEC, hqsc_pkg::ST_HALT_HOLD: begin
          torque_ramp_r <= (halt_decel_type == hqsc_pkg::HALT_TORQUE); // see (RULE_03)
          active_decel_r <= profile_decel; // see (RULE_07)
          active_current_r <= halt_lim; // see (RULE_05)
        end
        hqsc_pkg::ST_QS_DEC, hqsc_pkg::ST_QS_ACTIVE, hqsc_pkg::ST_FAULT: begin
          torque_ramp_r <= qs_torque; // see (RULE_10)
          active_decel_r <= qs_ramp_act_r;
          active_current_r <= qs_lim; // see (RULE_13)
        end
        default: begin
          torque_ramp_r <= 1'b0;
          active_decel_r <= profile_decel;
          active_current_r <= stage_peak_current;
        end
      endcase
      case (st_nxt)
        hqsc_pkg::ST_QS_ACTIVE: op_state_r <= hqsc_pkg::OPST_QS_ACTIVE; // see (RULE_11)
        hqsc_pkg::ST_FAULT: op_state_r <= hqsc_pkg::OPST_FAULT;
        default: op_state_r <= hqsc_pkg::OPST_ENABLED;
      endcase
    end
  end

  // stop end and release conditions, and the resume pulse, used by the checks below
  sequence qs_done_fault_s;
    st_r == hqsc_pkg::ST_QS_DEC && at_standstill && qs_fault;
  endsequence
  sequence qs_done_stay_s;
    st_r == hqsc_pkg::ST_QS_DEC && at_standstill && !qs_fault;
  endsequence
  sequence halt_release_s;
    st_r == hqsc_pkg::ST_HALT_HOLD && !halt_req && !qs_req;
  endsequence
  sequence resume_pulse_s;
    resume_r ##1 !resume_r;
  endsequence

  sel_lock_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_04)
    ramp_busy && par_wr && par_addr == hqsc_pkg::OFS_HALT_TYPE
    |=> $stable(halt_decel_type)) else $error("selector written during ramp");
  qs_lock_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_04)
    ramp_busy && par_wr && par_addr == hqsc_pkg::OFS_QS_REACT
    |=> $stable(quick_stop_reaction)) else $error("reaction written during ramp");
  qs_end_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_11)
    qs_done_fault_s |=> op_state_r == hqsc_pkg::OPST_FAULT)
    else $error("fault state missing");
  qs_stay_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_11)
    qs_done_stay_s |=> op_state_r == hqsc_pkg::OPST_QS_ACTIVE)
    else $error("quick stop active state missing");
  halt_go_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_02)
    st_r == hqsc_pkg::ST_RUN && halt_req && !qs_req
    |=> stopping_r && st_r == hqsc_pkg::ST_HALT_DEC) else $error("halt not started");
  qs_go_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_09)
    st_r == hqsc_pkg::ST_RUN && err_class2 |=> st_r == hqsc_pkg::ST_QS_DEC)
    else $error("quick stop not started");
  resume_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_14)
    halt_release_s |=> resume_pulse_s) else $error("resume not pulsed");
  halt_lim_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_05)
    st_r == hqsc_pkg::ST_HALT_DEC && $past(st_r) == hqsc_pkg::ST_HALT_DEC
    |-> active_current_r <= stage_peak_current || $changed(stage_peak_current))
    else $error("halt current above stage peak");
  // limit path lags its inputs by two cycles, so only settled inputs are judged
  halt_min_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_05) (RULE_08)
    st_r == hqsc_pkg::ST_HALT_DEC && $past(halt_current_limit, 2) == halt_current_limit &&
    $past(motor_peak_current, 2) == motor_peak_current &&
    $past(stage_peak_current, 2) == stage_peak_current && $past(i2t_current, 2) == i2t_current
    |-> active_current_r <= halt_current_limit && active_current_r <= motor_peak_current &&
    active_current_r <= stage_peak_current && active_current_r <= i2t_current)
    else $error("halt current not the lowest limit");
  qs_min_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_13)
    st_r == hqsc_pkg::ST_QS_DEC && $past(quick_stop_current_limit, 2) == quick_stop_current_limit &&
    $past(motor_peak_current, 2) == motor_peak_current &&
    $past(stage_peak_current, 2) == stage_peak_current && $past(i2t_current, 2) == i2t_current
    |-> active_current_r <= quick_stop_current_limit && active_current_r <= motor_peak_current &&
    active_current_r <= stage_peak_current && active_current_r <= i2t_current)
    else $error("quick stop current not the lowest limit");
  ramp_range_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_12)
    qs_ramp_r >= hqsc_pkg::QS_RAMP_MIN && qs_ramp_r <= hqsc_pkg::QS_RAMP_MAX)
    else $error("quick stop ramp out of range");
  ramp_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_12)
    !(move_start && st_r == hqsc_pkg::ST_RUN) |=> $stable(qs_ramp_act_r))
    else $error("quick stop ramp changed outside a movement start");
  halt_type_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_03)
    halt_decel_type == hqsc_pkg::HALT_RAMP || halt_decel_type == hqsc_pkg::HALT_TORQUE)
    else $error("bad halt selector");
  qs_type_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_10)
    quick_stop_reaction == hqsc_pkg::QS_TQ_FAULT ||
    quick_stop_reaction == hqsc_pkg::QS_RAMP_FAULT ||
    quick_stop_reaction == hqsc_pkg::QS_RAMP_STAY ||
    quick_stop_reaction == hqsc_pkg::QS_TQ_STAY) else $error("bad quick stop selector");
endmodule

/* File: tb/hqsc_motion_model.sv */
// Purpose: motion profile stand-in beside the stop logic
// Assumes: a stop always takes DEC_CYC cycles
// Notes: limit currents are fixed constants, not parameters
`timescale 1ns/1ps
module hqsc_motion_model #(
  parameter int DEC_CYC = 30,
  parameter logic [31:0] PDEC = 32'h0000_0BB8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic move_start,
  input wire logic resume_r,
  input wire logic stopping_r,
  output logic at_standstill,
  output logic [31:0] profile_decel,
  output logic [15:0] motor_peak_current,
  output logic [15:0] stage_peak_current,
  output logic [15:0] i2t_current
);
  logic moving_r;
  int cnt_r;
  assign at_standstill = !moving_r;
  assign profile_decel = PDEC;
  assign motor_peak_current = 16'h0500;
  assign stage_peak_current = 16'h0400;
  assign i2t_current = 16'h0600;
  // speed only reaches zero after a full ramp, never at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      moving_r <= 1'b0;
      cnt_r <= 0;
    end else if (move_start || resume_r) begin
      moving_r <= 1'b1;
      cnt_r <= 0;
    end else if (stopping_r) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == DEC_CYC - 1) begin
        moving_r <= 1'b0;
      end
    end else begin
      cnt_r <= 0;
    end
  end
endmodule

/* File: tb/hqsc_top_tb.sv */
// Purpose: self-checking bench for the stop logic
// Assumes: motion model answers stops after DCYC cycles
// Notes: a stop outlasts the register traffic made during it
`timescale 1ns/1ps
module hqsc_top_tb;
  localparam int DCYC = 30;
  localparam logic [31:0] PDEC = 32'h0000_0BB8;
  logic clk, rst_n, par_wr, halt_in, halt_cmd, qs_cmd, err_class1, err_class2;
  logic fault_reset, move_start, at_standstill, stopping_r, torque_ramp_r, resume_r;
  logic [15:0] par_addr, par_wdata, par_rdata_r, motor_peak_current, stage_peak_current;
  logic [15:0] i2t_current, active_current_r;
  logic [31:0] profile_decel, active_decel_r;
  logic [3:0] op_state_r;
  logic [15:0] codes [4] = '{16'hFFFE, 16'hFFFF, 16'h0006, 16'h0007};
  int errors, tests_run, k;
  hqsc_top dut (.clk, .rst_n, .par_wr, .par_addr, .par_wdata, .par_rdata_r, .halt_in,
    .halt_cmd, .qs_cmd, .err_class1, .err_class2, .fault_reset, .move_start, .at_standstill,
    .profile_decel, .motor_peak_current, .stage_peak_current, .i2t_current, .stopping_r,
    .torque_ramp_r, .active_decel_r, .active_current_r, .resume_r, .op_state_r);
  hqsc_motion_model #(.DEC_CYC(DCYC), .PDEC(PDEC)) model (.clk, .rst_n, .move_start,
    .resume_r, .stopping_r, .at_standstill, .profile_decel, .motor_peak_current,
    .stage_peak_current, .i2t_current);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    par_wr <= 1'b1;
    par_addr <= a;
    par_wdata <= d;
    @(posedge clk);
    par_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    par_addr <= a;
    tick(2);
    chk("par_rdata_r", {16'h0000, exp}, {16'h0000, par_rdata_r});
  endtask
  task automatic pulse_move;
    @(posedge clk);
    move_start <= 1'b1;
    @(posedge clk);
    move_start <= 1'b0;
    tick(1);
  endtask
  task automatic src(input int i, input logic v);
    if (i == 1) err_class1 <= v;
    else if (i == 2) err_class2 <= v;
    else qs_cmd <= v;
  endtask
  // resume is a single-cycle pulse, so it is checked low before the release, high once, then low the cycle after
  task automatic end_halt;
    chk("resume_r", 0, resume_r);
    @(posedge clk);
    halt_in <= 1'b0;
    halt_cmd <= 1'b0;
    tick(1);
    for (k = 0; k < 8 && resume_r !== 1'b1; k++)
      tick(1);
    chk("resume_r", 1, resume_r);
    tick(1);
    chk("resume_r", 0, resume_r);
  endtask
  task automatic wrap_up;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    wrap_up;
  end
  initial begin
    {par_wr, halt_in, halt_cmd, qs_cmd, err_class1, err_class2, fault_reset, move_start} = '0;
    par_addr = 16'h0000;
    par_wdata = 16'h0000;
    rst_n = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(hqsc_pkg::OFS_QS_RAMP_LO, 16'h1770);
    rd(hqsc_pkg::OFS_QS_RAMP_HI, 16'h0000);
    rd(hqsc_pkg::OFS_HALT_TYPE, hqsc_pkg::HALT_RAMP);
    rd(hqsc_pkg::OFS_QS_REACT, 16'h0006);
    rd(hqsc_pkg::OFS_HALT_CUR, 16'hFFFF);
    rd(hqsc_pkg::OFS_QS_CUR, 16'hFFFF);
    pulse_move;
    @(posedge clk);
    halt_in <= 1'b1;
    tick(4);
    chk("stopping_r", 1, stopping_r);
    chk("torque_ramp_r", 0, torque_ramp_r);
    chk("active_decel_r", PDEC, active_decel_r);
    chk("active_current_r", 16'h0400, active_current_r);
    wr(hqsc_pkg::OFS_HALT_TYPE, hqsc_pkg::HALT_TORQUE);
    wr(hqsc_pkg::OFS_HALT_CUR, 16'h0123);
    tick(3);
    chk("active_current_r", 16'h0123, active_current_r);
    rd(hqsc_pkg::OFS_HALT_TYPE, hqsc_pkg::HALT_RAMP);
    tick(DCYC);
    chk("stopping_r", 0, stopping_r);
    chk("op_state_r", 6, op_state_r);
    end_halt;
    wr(hqsc_pkg::OFS_HALT_TYPE, hqsc_pkg::HALT_TORQUE);
    @(posedge clk);
    halt_cmd <= 1'b1;
    tick(4);
    chk("torque_ramp_r", 1, torque_ramp_r);
    chk("active_current_r", 16'h0123, active_current_r);
    tick(DCYC);
    end_halt;
    // new ramp is written while running but only latched by the next movement
    wr(hqsc_pkg::OFS_QS_CUR, 16'h0200);
    wr(hqsc_pkg::OFS_QS_RAMP_LO, 16'h2000);
    wr(hqsc_pkg::OFS_QS_RAMP_HI, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(hqsc_pkg::OFS_QS_REACT, codes[i]);
      @(posedge clk);
      src(i, 1'b1);
      tick(4);
      chk("torque_ramp_r", (i == 0 || i == 3), torque_ramp_r);
      chk("active_decel_r", i == 0 ? 32'h0000_1770 : 32'h0000_2000, active_decel_r);
      chk("active_current_r", 16'h0200, active_current_r);
      wr(hqsc_pkg::OFS_QS_REACT, codes[3 - i]);
      rd(hqsc_pkg::OFS_QS_REACT, codes[i]);
      tick(DCYC);
      chk("op_state_r", i < 2 ? 4'h9 : 4'h7, op_state_r);
      rd(hqsc_pkg::OFS_STATUS, i < 2 ? 16'h0079 : 16'h0067);
      @(posedge clk);
      src(i, 1'b0);
      fault_reset <= 1'b1;
      @(posedge clk);
      fault_reset <= 1'b0;
      pulse_move;
      chk("op_state_r", 6, op_state_r);
    end
    wr(hqsc_pkg::OFS_QS_RAMP_LO, 16'h0000);
    wr(hqsc_pkg::OFS_QS_RAMP_HI, 16'h8000);
    rd(hqsc_pkg::OFS_QS_RAMP_HI, 16'h0000);
    rd(hqsc_pkg::OFS_QS_RAMP_LO, 16'h2000);
    // zero is below the ramp range, so this commit is dropped as well
    wr(hqsc_pkg::OFS_QS_RAMP_HI, 16'h0000);
    rd(hqsc_pkg::OFS_QS_RAMP_LO, 16'h2000);
    rd(hqsc_pkg::OFS_QS_CUR, 16'h0200);
    wr(hqsc_pkg::OFS_HALT_TYPE, 16'h0002);
    rd(hqsc_pkg::OFS_HALT_TYPE, hqsc_pkg::HALT_TORQUE);
    wrap_up;
  end
endmodule
